// ==== dv/boot_flash_bank_decode_bench.sv ====
// Self-checking bench for the boot window decoder and flash port settings.
module boot_flash_bank_decode_bench
  import flash_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        strap_high = 1'b0;
  logic        jumper_normal = 1'b0;
  logic [31:0] cpu_addr = 32'h0;
  logic        cpu_valid = 1'b0;
  logic        cpu_write = 1'b0;
  logic [1:0]  cpu_size = 2'h0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, sel_bank_a, sel_bank_b, sel_sdram, write_refused;
  logic [4:0]  bank_a_burst_bytes;
  logic [2:0]  bank_b_swap_bytes;
  logic        bank_b_boot_select, order_jumper;
  int          bank_b_hits;
  int          mismatches = 0;
  int          checks = 0;
  logic [31:0] rd;

  // Free-running 100 ns clock.
  always #50 clock = ~clock;

  boot_flash_bank_decode u_dut (.clock(clock), .rst(rst),
    .bank_b_boot_select(bank_b_boot_select), .order_jumper(order_jumper),
    .cpu_addr(cpu_addr), .cpu_valid(cpu_valid), .cpu_write(cpu_write), .cpu_size(cpu_size),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sel_bank_a(sel_bank_a), .sel_bank_b(sel_bank_b), .sel_sdram(sel_sdram),
    .write_refused(write_refused), .bank_a_burst_bytes(bank_a_burst_bytes),
    .bank_b_swap_bytes(bank_b_swap_bytes));

  host_board_model u_host (.clock(clock), .strap_high(strap_high),
    .jumper_normal(jumper_normal), .sel_bank_b(sel_bank_b),
    .bank_b_boot_select(bank_b_boot_select), .order_jumper(order_jumper),
    .bank_b_hits(bank_b_hits));

  task automatic stop_test();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access; the request is held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] data);
    @(posedge clock);
    avs_address <= idx;
    avs_writedata <= data;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // One processor cycle; selects and refusal stand for one cycle and are looked at there.
  task automatic cpu(input logic [31:0] a, input logic wr, input logic [1:0] sz,
                     input logic [3:0] exp);
    @(posedge clock);
    cpu_addr <= a;
    cpu_write <= wr;
    cpu_size <= sz;
    cpu_valid <= 1'b1;
    @(posedge clock);
    cpu_valid <= 1'b0;
    @(negedge clock);
    chk({28'h0, sel_bank_a, sel_bank_b, sel_sdram, write_refused}, {28'h0, exp});
  endtask : cpu

  // Strap is applied before release so the power-up sample sees it settled.
  task automatic do_reset(input logic strap);
    @(posedge clock);
    rst <= 1'b1;
    strap_high <= strap;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : do_reset

  task automatic t_reset_values();
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, ADDR_STATUS, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, {27'h0, 5'(BANK_A_BITS / 2)});
    bus(1'b0, ADDR_ID, 32'h0);
    chk(rd, BLOCK_ID);
    bus(1'b0, 4'hf, 32'h0);
    chk(rd, 32'h0);
    chk({27'h0, bank_a_burst_bytes}, {27'h0, SINGLE_BYTES});
    chk({29'h0, bank_b_swap_bytes}, {29'h0, SWAP_LEGACY});
  endtask : t_reset_values

  // Every control code: priority vec A, then vec B, then SDRAM alias, else nothing.
  task automatic t_routing();
    logic [3:0] exp;
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, ADDR_CTRL, 32'(c));
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'(c));
      exp = c[0] ? 4'b1000 : c[1] ? 4'b0100 : c[2] ? 4'b0010 : 4'b0000;
      cpu(32'hfff8_0000, 1'b0, SIZE_WORD, exp);
      cpu(32'hffef_fff0, 1'b0, SIZE_WORD, 4'b0000);
      chk({27'h0, bank_a_burst_bytes}, c[3] ? 32'(PAGE_BURST_BYTES) : 32'(SINGLE_BYTES));
    end
  endtask : t_routing

  task automatic t_write_sizes();
    bus(1'b1, ADDR_CTRL, 32'h1);
    cpu(32'hfff0_0001, 1'b1, SIZE_BYTE, 4'b1000);
    cpu(32'hfff0_0002, 1'b1, SIZE_HALF, 4'b1000);
    cpu(32'hfff0_0001, 1'b1, SIZE_HALF, 4'b0001);
    cpu(32'hfff0_0000, 1'b1, SIZE_WORD, 4'b0001);
    cpu(32'hfff0_0000, 1'b1, SIZE_DWORD, 4'b0001);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h28);
    bus(1'b1, ADDR_STATUS, 32'h20);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h8);
    // A control write without its low byte lane must leave the register alone.
    avs_byteenable <= 4'he;
    bus(1'b1, ADDR_CTRL, 32'h4);
    avs_byteenable <= 4'hf;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
  endtask : t_write_sizes

  task automatic t_jumper();
    jumper_normal <= 1'b1;
    repeat (10) @(posedge clock);
    chk({29'h0, bank_b_swap_bytes}, {29'h0, SWAP_NORMAL});
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h18);
    jumper_normal <= 1'b0;
  endtask : t_jumper

  // A second reset with the host strap high must hand the boot window to bank B.
  task automatic t_strap_b();
    int h;
    do_reset(1'b1);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h2);
    h = bank_b_hits;
    cpu(32'hffff_fffc, 1'b0, SIZE_WORD, 4'b0100);
    @(negedge clock);
    chk(32'(bank_b_hits - h), 32'h1);
  endtask : t_strap_b

  // Watchdog sized well past the few hundred cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    t_reset_values();
    t_routing();
    t_write_sizes();
    t_jumper();
    t_strap_b();
    stop_test();
  end
endmodule : boot_flash_bank_decode_bench

// ==== dv/host_board_model.sv ====
// Host board model: drives the boot strap pin and ordering jumper, counts bank B selects.
module host_board_model (
  input  wire logic clock,
  input  wire logic strap_high,
  input  wire logic jumper_normal,
  input  wire logic sel_bank_b,
  output logic      bank_b_boot_select,
  output logic      order_jumper,
  output int        bank_b_hits
);
  timeunit 1ns;
  timeprecision 1ns;

  // Both pins start low, so power-up sees the default bank and legacy ordering.
  initial begin
    bank_b_boot_select = 1'b0;
    order_jumper       = 1'b0;
    bank_b_hits        = 0;
  end

  // The pins are board straps: they only move when the bench asks, right after an edge.
  always @(posedge clock) begin
    bank_b_boot_select <= strap_high;
    order_jumper <= jumper_normal;
    if (sel_bank_b === 1'b1) begin
      bank_b_hits <= bank_b_hits + 1;
    end
  end
endmodule : host_board_model

// ==== inc/flash_decode_pkg.sv ====
// Constants and types shared by the boot flash bank decoder.
package flash_decode_pkg;
  // Avalon register map, word addresses on a 32-bit data bus.
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_ID     = 4'h2;
  // Control register fields.
  localparam int CTRL_VEC_A    = 0;
  localparam int CTRL_VEC_B    = 1;
  localparam int CTRL_ALIAS    = 2;
  localparam int CTRL_BURST    = 3;
  // Status register fields.
  localparam int STAT_WIDTH_LO = 0;
  localparam int STAT_ORDER    = 4;
  localparam int STAT_WERR     = 5;
  localparam int STAT_WIDTH_W  = 4;
  // Identification word, value arbitrary.
  localparam logic [31:0] BLOCK_ID = 32'h0000_0a5c;
  // Boot window occupies the top 1 MB: address bits 31..20 all set.
  localparam logic [11:0] BOOT_WINDOW_TAG = 12'hfff;
  // Widths in bits of the two flash banks.
  localparam logic [4:0] BANK_A_BITS = 5'h10;
  localparam logic [4:0] BANK_B_BITS = 5'h10;
  // Burst length in bytes on the on-board flash port with page mode.
  localparam logic [4:0] PAGE_BURST_BYTES = 5'h10;
  localparam logic [4:0] SINGLE_BYTES     = 5'h02;
  // Bytes per data lane swap: legacy every four, normal every one.
  localparam logic [2:0] SWAP_LEGACY = 3'h4;
  localparam logic [2:0] SWAP_NORMAL = 3'h1;
  // Transfer sizes for writes into the on-board bank.
  typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD, SIZE_DWORD} xfer_size_t;
  typedef enum logic [1:0] {TGT_NONE, TGT_BANK_A, TGT_BANK_B, TGT_SDRAM} boot_target_t;
endpackage : flash_decode_pkg

// ==== src/boot_flash_bank_decode.sv ====
// Boot window decoder and flash port configuration for two flash banks.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
module boot_flash_bank_decode
  import flash_decode_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        bank_b_boot_select,
  input  wire logic        order_jumper,
  input  wire logic [31:0] cpu_addr,
  input  wire logic        cpu_valid,
  input  wire logic        cpu_write,
  input  wire logic [1:0]  cpu_size,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             sel_bank_a,
  output logic             sel_bank_b,
  output logic             sel_sdram,
  output logic             write_refused,
  output logic [4:0]       bank_a_burst_bytes,
  output logic [2:0]       bank_b_swap_bytes
);

  // Three-stage synchronisers for the two pins; a change counts when stages two and three agree.
  logic [2:0] sel_sync;
  logic [2:0] ord_sync;
  logic       sel_level;
  logic       ord_level;
  logic       strap_done;
  logic [2:0] strap_settle;
  logic       boot_vec_en_bank_a;
  logic       boot_vec_en_bank_b;
  logic       sdram_boot_alias_en;
  logic       page_burst_en;
  logic       sticky_werr;
  logic       ack;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_sync <= 3'h0;
      ord_sync <= 3'h0;
    end else begin
      sel_sync <= {sel_sync[1:0], bank_b_boot_select};
      ord_sync <= {ord_sync[1:0], order_jumper};
    end
  end

  // Filtered levels follow only when the last two stages agree.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_level <= 1'b0;
      ord_level <= 1'b0;
    end else begin
      if (sel_sync[1] == sel_sync[2]) begin
        sel_level <= sel_sync[2];
      end
      if (ord_sync[1] == ord_sync[2]) begin
        ord_level <= ord_sync[2];
      end
    end
  end

  // Bus decode wires.
  wire hit_ctrl   = avs_address == ADDR_CTRL;
  wire hit_status = avs_address == ADDR_STATUS;
  wire hit_id     = avs_address == ADDR_ID;
  // Writes land at the edge where waitrequest is seen low, the one edge the master counts.
  wire ctrl_wr    = avs_write && ack && hit_ctrl && avs_byteenable[0];
  wire strap_load = !strap_done && strap_settle[2] && (sel_sync[1] == sel_sync[2]) &&
                    (sel_level == sel_sync[2]);

  // Settle marker: fills with ones after release, so the strap is never taken from the
  // reset zeros of the synchroniser before the pin has travelled through all three stages.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_settle <= 3'h0;
    end else begin
      strap_settle <= {strap_settle[1:0], 1'b1};
    end
  end

  // The strap is taken a few cycles after reset release, once the filter has settled,
  // so a pin that was still moving at release is not latched half-way.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_done <= 1'b0;
    end else if (strap_load) begin
      strap_done <= 1'b1;
    end
  end

  // Vector enables: power-up strap first, software may rewrite them later.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_vec_en_bank_a <= 1'b1;
      boot_vec_en_bank_b <= 1'b0;
    end else if (strap_load) begin
      // bank A default, B by select
      boot_vec_en_bank_a <= !sel_level;
      boot_vec_en_bank_b <= sel_level;
    end else if (ctrl_wr) begin
      boot_vec_en_bank_a <= avs_writedata[CTRL_VEC_A];
      boot_vec_en_bank_b <= avs_writedata[CTRL_VEC_B];
    end
  end

  // Software-only bits of the control register.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sdram_boot_alias_en <= 1'b0;
      page_burst_en       <= 1'b0;
    end else if (ctrl_wr) begin
      sdram_boot_alias_en <= avs_writedata[CTRL_ALIAS];
      page_burst_en       <= avs_writedata[CTRL_BURST];
    end
  end

  // Boot window and routing priority: bank A, then bank B, then SDRAM alias, else nothing.
  wire in_window = cpu_addr[31:20] == BOOT_WINDOW_TAG;
  boot_target_t target;
  always_comb begin
    target = TGT_NONE;
    if (in_window) begin
      if (boot_vec_en_bank_a) begin
        target = TGT_BANK_A;
      end else if (boot_vec_en_bank_b) begin
        target = TGT_BANK_B;
      end else if (sdram_boot_alias_en) begin
        target = TGT_SDRAM;
      end else begin
        target = TGT_NONE;
      end
    end
  end

  // Write size check for the on-board bank; words would split across the 16-bit path badly.
  xfer_size_t wsize;
  assign wsize = xfer_size_t'(cpu_size);
  wire size_ok = (wsize == SIZE_BYTE) || (wsize == SIZE_HALF && !cpu_addr[0]);
  // refuse bad writes to bank A
  wire bad_write = cpu_valid && cpu_write && target == TGT_BANK_A && !size_ok;

  // Selects are registered; a refused write never reaches bank A.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_bank_a    <= 1'b0;
      sel_bank_b    <= 1'b0;
      sel_sdram     <= 1'b0;
      write_refused <= 1'b0;
    end else begin
      sel_bank_a    <= cpu_valid && target == TGT_BANK_A && !bad_write;
      sel_bank_b    <= cpu_valid && target == TGT_BANK_B;
      sel_sdram     <= cpu_valid && target == TGT_SDRAM;
      write_refused <= bad_write;
    end
  end

  // Sticky error flag: a new error in the clearing cycle wins over the clear.
  wire werr_clr = avs_write && ack && hit_status && avs_writedata[STAT_WERR];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sticky_werr <= 1'b0;
    end else if (bad_write) begin
      sticky_werr <= 1'b1;
    end else if (werr_clr) begin
      sticky_werr <= 1'b0;
    end
  end

  // Port configuration outputs.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bank_a_burst_bytes <= SINGLE_BYTES;
      bank_b_swap_bytes  <= SWAP_LEGACY;
    end else begin
      bank_a_burst_bytes <= page_burst_en ? PAGE_BURST_BYTES : SINGLE_BYTES;
      bank_b_swap_bytes  <= ord_level ? SWAP_NORMAL : SWAP_LEGACY;
    end
  end

  // Read mux. Width fields are constants: the hardware settles them, software cannot.
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[CTRL_VEC_A] = boot_vec_en_bank_a;
    ctrl_word[CTRL_VEC_B] = boot_vec_en_bank_b;
    ctrl_word[CTRL_ALIAS] = sdram_boot_alias_en;
    ctrl_word[CTRL_BURST] = page_burst_en;
    stat_word = 32'h0;
    stat_word[STAT_WIDTH_LO +: STAT_WIDTH_W] = BANK_A_BITS[4:1];
    stat_word[STAT_ORDER] = ord_level;
    stat_word[STAT_WERR]  = sticky_werr;
  end
  wire [31:0] read_mux = hit_ctrl   ? ctrl_word :
                         hit_status ? stat_word :
                         hit_id     ? BLOCK_ID  : 32'h0;

  // One wait cycle: request seen, answer at the next edge with waitrequest low. Waitrequest
  // is a flop of its own so the pin carries no gate after the clock.
  wire next_ack = (avs_read || avs_write) && !ack;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack             <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      ack             <= next_ack;
      avs_waitrequest <= !next_ack;
      avs_readdata    <= (avs_read && !ack) ? read_mux : avs_readdata;
    end
  end

  // Checks.
  a_route_bank_a: assert property (@(posedge clock) disable iff (rst)
    cpu_valid && in_window && boot_vec_en_bank_a && !bad_write |=> sel_bank_a)
    else $error("bank A not selected");
  a_route_bank_b: assert property (@(posedge clock) disable iff (rst)
    cpu_valid && in_window && !boot_vec_en_bank_a && boot_vec_en_bank_b |=> sel_bank_b)
    else $error("bank B not selected");
  a_alias_sdram: assert property (@(posedge clock) disable iff (rst)
    cpu_valid && in_window && !boot_vec_en_bank_a && !boot_vec_en_bank_b
    && sdram_boot_alias_en |=> sel_sdram && !sel_bank_a)
    else $error("sdram alias missed");
  a_window_none: assert property (@(posedge clock) disable iff (rst)
    cpu_valid && !(boot_vec_en_bank_a || boot_vec_en_bank_b || sdram_boot_alias_en)
    |=> !sel_bank_a && !sel_bank_b && !sel_sdram)
    else $error("window decoded with nothing enabled");
  a_write_size: assert property (@(posedge clock) disable iff (rst)
    bad_write |=> write_refused && !sel_bank_a ##1 sticky_werr || bad_write)
    else $error("bad write reached bank A");
  a_strap_vec: assert property (@(posedge clock) disable iff (rst)
    strap_load |=> boot_vec_en_bank_b == $past(sel_level) && boot_vec_en_bank_a != boot_vec_en_bank_b)
    else $error("strap not loaded");
  a_burst_size: assert property (@(posedge clock) disable iff (rst)
    page_burst_en && !ctrl_wr |=> ##1 bank_a_burst_bytes == PAGE_BURST_BYTES)
    else $error("burst size wrong");
  a_order_swap: assert property (@(posedge clock) disable iff (rst)
    ord_level |=> bank_b_swap_bytes == SWAP_NORMAL)
    else $error("ordering swap wrong");
  a_bus_answer: assert property (@(posedge clock) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  // Bus handshake: waitrequest is low for one cycle and read data is the decoded word.
  a_bus_release: assert property (@(posedge clock) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest held low");
  a_read_data: assert property (@(posedge clock) disable iff (rst)
    avs_read && avs_waitrequest |=> avs_readdata == $past(read_mux))
    else $error("read data not the selected word");

  // Routing outside the window, exclusive selects, the sticky write error flag and the alias enable write.
  a_window_outside: assert property (@(posedge clock) disable iff (rst)
    cpu_valid && !in_window |=> !sel_bank_a && !sel_bank_b && !sel_sdram)
    else $error("access outside boot window selected");
  a_sdram_exclusive: assert property (@(posedge clock) disable iff (rst)
    sel_sdram |-> !sel_bank_a && !sel_bank_b)
    else $error("sdram and flash selected together");
  a_werr_set_wins: assert property (@(posedge clock) disable iff (rst)
    bad_write |=> sticky_werr)
    else $error("write error flag lost");
  a_ctrl_write: assert property (@(posedge clock) disable iff (rst)
    ctrl_wr && !strap_load |=> sdram_boot_alias_en == $past(avs_writedata[CTRL_ALIAS]))
    else $error("alias enable not written");

  // Port settings follow their sources one cycle later.
  a_burst_single: assert property (@(posedge clock) disable iff (rst)
    !page_burst_en |=> bank_a_burst_bytes == SINGLE_BYTES)
    else $error("single burst size wrong");
  a_legacy_swap: assert property (@(posedge clock) disable iff (rst)
    !ord_level |=> bank_b_swap_bytes == SWAP_LEGACY)
    else $error("legacy ordering wrong");
  c_boot_a: cover property (@(posedge clock) disable iff (rst) sel_bank_a);
  c_boot_b: cover property (@(posedge clock) disable iff (rst) sel_bank_b);
  c_sdram:  cover property (@(posedge clock) disable iff (rst) sel_sdram);
  c_refuse: cover property (@(posedge clock) disable iff (rst) write_refused);
  c_page_burst: cover property (@(posedge clock) disable iff (rst)
    bank_a_burst_bytes == PAGE_BURST_BYTES);

endmodule : boot_flash_bank_decode
